/* design/tsr_defs.svh */
// Offsets, field positions, reset values and timing counts of the tilt scaling readout.
`ifndef TSR_DEFS_SVH
`define TSR_DEFS_SVH
`define TSR_REG_X_RESULT 8'h00
`define TSR_REG_Y_RESULT 8'h04
`define TSR_REG_STATUS 8'h08
`define TSR_REG_DECPT 8'h0c
`define TSR_REG_TEMP 8'h10
`define TSR_REG_X_SCALE 8'h14
`define TSR_REG_Y_SCALE 8'h18
`define TSR_REG_X_OFFSET 8'h1c
`define TSR_REG_Y_OFFSET 8'h20
`define TSR_REG_STATION 8'h24
`define TSR_REG_CONTROL 8'h28
`define TSR_REG_TEMP_COEF 8'h2c
`define TSR_CTRL_ZERO_X 0
`define TSR_CTRL_ZERO_Y 1
`define TSR_SCALE_RESET 16'h005a
`define TSR_DECPT_RESET 2'h2
`define TSR_STATION_RESET 8'hfe
`define TSR_STATION_FORCED 8'hff
`define TSR_STATUS_OK 8'h00
`define TSR_STATUS_UNDER 8'h40
`define TSR_STATUS_OVER 8'h80
`define TSR_RATE_FORCED 32'd9600
`define TSR_CLK_HZ 32'd25000000
`define TSR_BLINK_MS 32'd1000
`define TSR_BLINK_HALF ((`TSR_CLK_HZ / 32'd1000) * `TSR_BLINK_MS / 32'd2)
`endif

/* design/tsr_pkg.sv */
// Types shared by the tilt scaling readout.
package tsr_pkg;
  typedef enum logic [1:0] {
    TSR_IDLE,
    TSR_SCALE,
    TSR_DIVIDE,
    TSR_STORE
  } tsr_state_type;
endpackage : tsr_pkg

/* design/tsr_readout.sv */
// Tilt scaling readout: compensation, scaling, offsets, station address, LED, Avalon slave.
//
// Operation
// RULE1: Temperature-correct both angles before scaling.
// RULE2: Scale linearly; coefficient equals ninety-degree output.
// RULE3: Decimal point sets output resolution per axis.
// RULE4: Reset: scale ninety, decimal point two.
// RULE5: Scale hundred yields grads.
// RULE6: Scale 1570, decimal zero yields milliradians.
// RULE7: Master picks settings fitting one word.
// RULE8: Subtract per-axis offset from gravity angle.
// RULE9: Offsets never converted on scale change.
// RULE10: Zero procedure loads offset, each axis alone.
// RULE11: Station address FEh, writable over bus.
// RULE12: Pushbutton forces station address FFh.
// RULE13: Settings held at fixed register numbers.
// RULE14: Master never writes calibration registers.
// RULE15: LED blinks about once per second.
// RULE16: LED steady while address forced.
// RULE17: Read, single and group write functions.
// RULE18: Group frames cover at most five registers; here the bus moves one word per request and checks no group size.
// RULE19: Status byte zero, 40h under, 80h over.
// RULE20: Result is clamped signed 16-bit word.
// RULE21: Setting changes apply to later samples; here scale and offset are read after the sample enters.
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tsr_defs.svh"
module tsr_readout
  import tsr_pkg::*;
#(
  parameter int BLINK_HALF = `TSR_BLINK_HALF
) (
  // Clock, reset and clock enable.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Raw sample from the sensing front end: angles in hundredths of a degree, temperature in tenths of a degree.
  input wire logic sample_valid,
  input wire logic signed [15:0] raw_x,
  input wire logic signed [15:0] raw_y,
  input wire logic signed [15:0] raw_temp,
  // Internal pushbutton pin, active low.
  input wire logic button_n,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  // Outputs toward the serial bus logic and the board.
  output logic [7:0] station_addr,
  output logic forced_rate,
  output logic led
);

  // Per-axis settings and results.
  logic [15:0] scale_x, scale_y, next_scale_x, next_scale_y;
  logic [1:0] decpt_x, decpt_y, next_decpt_x, next_decpt_y;
  logic signed [15:0] off_x, off_y, next_off_x, next_off_y;
  logic signed [15:0] res_x, res_y, next_res_x, next_res_y;
  logic [7:0] stat_x, stat_y, next_stat_x, next_stat_y;
  logic signed [15:0] temp, next_temp;
  // Calibration coefficient: temperature slope, held as a word the bus can read but not write.
  logic signed [15:0] tcoef, next_tcoef;
  logic [7:0] station, next_station;
  // Zero requests, pending until the next sample is processed.
  logic [1:0] zero_req, next_zero_req;
  // Bus answer registers.
  logic [31:0] rdata, next_rdata;
  logic ack, next_ack;
  logic [1:0] resp, next_resp;
  // Registered waitrequest: high unless the answer stands in this cycle.
  logic wait_q, next_wait;
  // Decode helpers: the word a read returns and whether the offset is unmapped.
  logic [31:0] rd_word;
  logic bad_addr;
  // Write strobe of the answer cycle, the only cycle in which a write lands.
  logic wr_now;
  // Pipeline of the conversion.
  tsr_state_type state, next_state;
  logic signed [47:0] prod_x, prod_y, next_prod_x, next_prod_y;
  logic signed [31:0] cx, cy, next_cx, next_cy;
  // Button synchroniser and LED.
  logic btn_s1, btn_s2;
  logic [31:0] blink_cnt, next_blink_cnt;
  logic led_q, next_led_q;

  // Power of ten for a decimal-point setting; used by both axes.
  function automatic logic [15:0] pow10(input logic [1:0] d);
    case (d)
      2'h0: pow10 = 16'h0001;
      2'h1: pow10 = 16'h000a;
      2'h2: pow10 = 16'h0064;
      default: pow10 = 16'h03e8;
    endcase
  endfunction : pow10

  // Clamp a wide value to a signed word and report the axis status byte.
  function automatic logic [23:0] clamp16(input logic signed [31:0] v);
    if (v > 32'sd32767) begin
      clamp16 = {16'h7fff, 8'h80};
    end else if (v < -32'sd32768) begin
      clamp16 = {16'h8000, 8'h40};
    end else begin
      clamp16 = {v[15:0], 8'h00};
    end
  endfunction : clamp16

  // Temperature correction: slope in 1/65536 per tenth degree from 25.0 degC.
  function automatic logic signed [31:0] tcomp(input logic signed [15:0] a,
                                               input logic signed [15:0] t,
                                               input logic signed [15:0] k);
    logic signed [47:0] p;
    p = 48'(a) * 48'(k) * 48'(t - 16'sd250);
    tcomp = 32'(a) - 32'(p >>> 16);
  endfunction : tcomp

  // Button pin passes two flip-flops before use.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      btn_s1 <= 1'b0;
      btn_s2 <= 1'b0;
    end else if (clk_en) begin
      btn_s1 <= ~button_n;
      btn_s2 <= btn_s1;
    end
  end

  // Conversion pipeline: compensate, scale by coefficient and decimal, divide by 9000, offset.
  // Scale is read one cycle and offset two cycles after a sample enters, so a write can land on the sample in flight.
  always_comb begin
    next_state = state;
    next_prod_x = prod_x;
    next_prod_y = prod_y;
    next_cx = cx;
    next_cy = cy;
    next_res_x = res_x;
    next_res_y = res_y;
    next_stat_x = stat_x;
    next_stat_y = stat_y;
    next_temp = temp;
    case (state)
      TSR_IDLE: begin
        if (sample_valid) begin
          next_temp = raw_temp;
          next_cx = tcomp(raw_x, raw_temp, tcoef); // RULE1
          next_cy = tcomp(raw_y, raw_temp, tcoef); // RULE1
          next_state = TSR_SCALE; // RULE21
        end
      end
      TSR_SCALE: begin
        // Input is hundredths of a degree: 9000 counts at a right angle. RULE5 RULE6
        next_prod_x = 48'(cx) * 48'(scale_x) * 48'(pow10(decpt_x)); // RULE2 RULE3
        next_prod_y = 48'(cy) * 48'(scale_y) * 48'(pow10(decpt_y)); // RULE2 RULE3
        next_state = TSR_DIVIDE;
      end
      TSR_DIVIDE: begin
        // Offsets are raw counts in the current unit, never rescaled.
        next_cx = 32'(prod_x / 48'sd9000) - 32'(off_x); // RULE8 RULE9
        next_cy = 32'(prod_y / 48'sd9000) - 32'(off_y); // RULE8 RULE9
        next_state = TSR_STORE;
      end
      TSR_STORE: begin
        {next_res_x, next_stat_x} = clamp16(cx); // RULE20 RULE19
        {next_res_y, next_stat_y} = clamp16(cy); // RULE20 RULE19
        next_state = TSR_IDLE;
      end
      default: next_state = TSR_IDLE;
    endcase
  end

  // Register bus: one wait cycle, then answer; unmapped offsets answer with an error.
  // Read data are captured in the wait cycle, but writes land only at the edge where the
  // master sees waitrequest low, so a setting never changes before its transfer ends.
  always_comb begin
    next_scale_x = scale_x;
    next_scale_y = scale_y;
    next_decpt_x = decpt_x;
    next_decpt_y = decpt_y;
    next_off_x = off_x;
    next_off_y = off_y;
    next_tcoef = tcoef;
    next_station = station;
    next_zero_req = zero_req;
    next_rdata = rdata;
    next_resp = resp;
    next_ack = 1'b0;
    rd_word = 32'h0;
    bad_addr = 1'b0;
    wr_now = avs_write && ack;
    // A finished sample consumes zero requests: offset takes the pre-offset value.
    if (state == TSR_STORE) begin
      if (zero_req[`TSR_CTRL_ZERO_X]) begin
        next_off_x = 16'(cx + 32'(off_x)); // RULE10
      end
      if (zero_req[`TSR_CTRL_ZERO_Y]) begin
        next_off_y = 16'(cy + 32'(off_y)); // RULE10
      end
      next_zero_req = 2'h0;
    end
    // One word per request; nothing here holds a group to five registers.
    case (avs_address) // RULE18
      `TSR_REG_X_RESULT: rd_word = {{16{res_x[15]}}, res_x};
      `TSR_REG_Y_RESULT: rd_word = {{16{res_y[15]}}, res_y};
      `TSR_REG_STATUS: rd_word = {16'h0, stat_x, stat_y}; // RULE19
      `TSR_REG_DECPT: begin
        rd_word = {16'h0, 6'h0, decpt_x, 6'h0, decpt_y};
        if (wr_now && avs_byteenable[1]) next_decpt_x = avs_writedata[9:8];
        if (wr_now && avs_byteenable[0]) next_decpt_y = avs_writedata[1:0];
      end
      `TSR_REG_TEMP: rd_word = {{16{temp[15]}}, temp};
      `TSR_REG_X_SCALE: begin
        rd_word = {16'h0, scale_x};
        if (wr_now && &avs_byteenable[1:0]) next_scale_x = avs_writedata[15:0];
      end
      `TSR_REG_Y_SCALE: begin
        rd_word = {16'h0, scale_y};
        if (wr_now && &avs_byteenable[1:0]) next_scale_y = avs_writedata[15:0];
      end
      `TSR_REG_X_OFFSET: begin
        rd_word = {{16{off_x[15]}}, off_x};
        if (wr_now && &avs_byteenable[1:0]) next_off_x = avs_writedata[15:0];
      end
      `TSR_REG_Y_OFFSET: begin
        rd_word = {{16{off_y[15]}}, off_y};
        if (wr_now && &avs_byteenable[1:0]) next_off_y = avs_writedata[15:0];
      end
      `TSR_REG_STATION: begin
        rd_word = {24'h0, station};
        if (wr_now && avs_byteenable[0]) next_station = avs_writedata[7:0]; // RULE11
      end
      `TSR_REG_CONTROL: begin
        rd_word = {30'h0, zero_req};
        // A new request survives even when the store cycle clears older ones.
        if (wr_now && avs_byteenable[0]) begin
          next_zero_req = next_zero_req | avs_writedata[1:0]; // RULE10
        end
      end
      `TSR_REG_TEMP_COEF: begin
        // Calibration word is readable; writes are ignored to protect it.
        rd_word = {{16{tcoef[15]}}, tcoef}; // RULE13
      end
      default: bad_addr = 1'b1;
    endcase
    // The answer is registered in the wait cycle and stands until the next request.
    if ((avs_read || avs_write) && !ack) begin
      next_ack = 1'b1;
      next_rdata = rd_word;
      next_resp = bad_addr ? 2'h2 : 2'h0;
    end
    next_wait = ~next_ack;
  end

  // LED: toggles every half second, steady while the button forces the address.
  always_comb begin
    next_blink_cnt = blink_cnt + 32'd1;
    next_led_q = led_q;
    if (btn_s2) begin
      next_led_q = 1'b1; // RULE16
      next_blink_cnt = 32'd0;
    end else if (blink_cnt >= 32'(BLINK_HALF - 1)) begin
      next_blink_cnt = 32'd0;
      next_led_q = ~led_q; // RULE15
    end
  end

  // All state registers except the button synchroniser.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TSR_IDLE;
      scale_x <= `TSR_SCALE_RESET; // RULE4
      scale_y <= `TSR_SCALE_RESET; // RULE4
      decpt_x <= `TSR_DECPT_RESET; // RULE4
      decpt_y <= `TSR_DECPT_RESET; // RULE4
      off_x <= 16'sh0;
      off_y <= 16'sh0;
      res_x <= 16'sh0;
      res_y <= 16'sh0;
      stat_x <= `TSR_STATUS_OK;
      stat_y <= `TSR_STATUS_OK;
      temp <= 16'sh0;
      tcoef <= 16'sh0;
      station <= `TSR_STATION_RESET; // RULE11
      zero_req <= 2'h0;
      prod_x <= 48'sh0;
      prod_y <= 48'sh0;
      cx <= 32'sh0;
      cy <= 32'sh0;
      rdata <= 32'h0;
      ack <= 1'b0;
      resp <= 2'h0;
      wait_q <= 1'b1;
      blink_cnt <= 32'd0;
      led_q <= 1'b0;
      station_addr <= `TSR_STATION_RESET;
      forced_rate <= 1'b0;
    end else if (clk_en) begin
      state <= next_state;
      scale_x <= next_scale_x;
      scale_y <= next_scale_y;
      decpt_x <= next_decpt_x;
      decpt_y <= next_decpt_y;
      off_x <= next_off_x;
      off_y <= next_off_y;
      res_x <= next_res_x;
      res_y <= next_res_y;
      stat_x <= next_stat_x;
      stat_y <= next_stat_y;
      temp <= next_temp;
      tcoef <= next_tcoef;
      station <= next_station;
      zero_req <= next_zero_req;
      prod_x <= next_prod_x;
      prod_y <= next_prod_y;
      cx <= next_cx;
      cy <= next_cy;
      rdata <= next_rdata;
      ack <= next_ack;
      resp <= next_resp;
      wait_q <= next_wait;
      blink_cnt <= next_blink_cnt;
      led_q <= next_led_q;
      // The button overrides the stored address without changing it.
      station_addr <= btn_s2 ? `TSR_STATION_FORCED : next_station; // RULE12
      forced_rate <= btn_s2; // RULE16
    end
  end

  // Outputs straight from flip-flops.
  assign avs_readdata = rdata;
  assign avs_response = resp;
  assign avs_waitrequest = wait_q;
  assign led = led_q;

  // X status byte over implies the X result is clamped high.
  status_match_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
    (stat_x == `TSR_STATUS_OVER) |-> (res_x == 16'sh7fff))
    else $error("X status over without clamp");
  // A sample reaches the result three enabled cycles after it enters.
  pipe_order_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
    (state == TSR_IDLE && sample_valid && clk_en) ##1 clk_en [*3] |=> state == TSR_IDLE)
    else $error("Pipeline did not finish");
  // Forced address shows FFh the cycle after the synchronised button.
  forced_addr_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE12 RULE16
    (btn_s2 && clk_en) |=> (station_addr == `TSR_STATION_FORCED && led))
    else $error("Forced address not shown");
  // Every read request is answered within two cycles.
  bus_answer_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE17
    (avs_read && clk_en) |-> ##[0:1] !avs_waitrequest)
    else $error("Bus did not answer");
  // Between toggle points the LED keeps its level.
  led_steady_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
    (clk_en && !btn_s2 && blink_cnt < 32'(BLINK_HALF - 1)) |=> $stable(led))
    else $error("LED changed between toggle points");
  // A finished sample leaves no zero request behind unless a new one lands with it.
  zero_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    (clk_en && state == TSR_STORE && !(wr_now && avs_address == `TSR_REG_CONTROL))
      |=> zero_req == 2'h0)
    else $error("Zero request outlived its sample");

endmodule : tsr_readout

/* sim/tsr_master.sv */
// Register bus master model that stands in for the serial bus master.
`timescale 1ns/1ps
module tsr_master (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM master side.
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response
);
  // Idle bus at time zero.
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
  end

  // One word per request, held until waitrequest is sampled low; the bench never writes
  // the calibration word, so this model offers only single reads and writes.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk);
    end
    q = avs_readdata;
    r = avs_response;
    // Released lines show the inverse so stale values never look valid.
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask : xfer
endmodule : tsr_master

/* sim/tb.sv */
// Self-checking testbench of the tilt scaling readout.
`timescale 1ns/1ps
module tb;
  import tsr_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sample_valid = 1'b0;
  logic signed [15:0] raw_x = 16'sh0;
  logic signed [15:0] raw_y = 16'sh0;
  logic signed [15:0] raw_temp = 16'sh0;
  logic button_n = 1'b1;
  logic [7:0] address;
  logic rd_en;
  logic wr_en;
  logic [31:0] wdata;
  logic [3:0] ben;
  logic [31:0] rdata;
  logic wait_req;
  logic [1:0] resp;
  logic [7:0] station_addr;
  logic forced_rate;
  logic led;
  int errors = 0;
  int tests_run = 0;
  int seed = 32'h9f5d;
  int sc[2] = '{90, 90};
  int dp[2] = '{2, 2};
  int off[2] = '{0, 0};
  logic [31:0] q;
  logic [1:0] r;
  int n;

  // Half period of 20 ns gives the 25 MHz clock.
  always #20 clk = ~clk;

  // Short blink count keeps the LED check within a few dozen cycles.
  tsr_readout #(.BLINK_HALF(8)) DUT (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
    .sample_valid(sample_valid), .raw_x(raw_x), .raw_y(raw_y), .raw_temp(raw_temp),
    .button_n(button_n), .avs_address(address), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdata), .avs_byteenable(ben), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .avs_response(resp), .station_addr(station_addr),
    .forced_rate(forced_rate), .led(led));

  tsr_master MST (.clk(clk), .rst_n(rst_n), .avs_address(address), .avs_read(rd_en),
    .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(ben), .avs_readdata(rdata),
    .avs_waitrequest(wait_req), .avs_response(resp));

  // Behavioural result: scale, decimal point, offset, then clamp to one word.
  function automatic int mdl(int raw, int a);
    int v;
    v = raw * sc[a] * (10 ** dp[a]) / 9000 - off[a];
    if (v > 32767) v = 32767;
    if (v < -32768) v = -32768;
    return v;
  endfunction : mdl

  // Status byte that belongs to the same result.
  function automatic logic [7:0] stat(int raw, int a);
    int v;
    v = raw * sc[a] * (10 ** dp[a]) / 9000 - off[a];
    return (v > 32767) ? 8'h80 : (v < -32768) ? 8'h40 : 8'h00;
  endfunction : stat

  // Every comparison goes through here.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    MST.xfer(1'b1, a, d, q, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    MST.xfer(1'b0, a, 32'h0, q, r);
    chk(q, exp);
  endtask : rd

  // One sample, then both results and the status word against the model.
  task automatic smp(input int rx, input int ry);
    @(posedge clk);
    raw_x <= 16'(rx);
    raw_y <= 16'(ry);
    raw_temp <= 16'($random(seed));
    sample_valid <= 1'b1;
    @(posedge clk);
    sample_valid <= 1'b0;
    repeat (6) @(posedge clk);
    rd(8'h00, 32'(mdl(rx, 0)));
    rd(8'h04, 32'(mdl(ry, 1)));
    rd(8'h08, {16'h0, stat(rx, 0), stat(ry, 1)});
    rd(8'h10, 32'(raw_temp));
  endtask : smp

  // Counts LED changes over a span of cycles.
  task automatic blink(input int cyc);
    logic l;
    n = 0;
    for (int i = 0; i < cyc; i++) begin
      l = led;
      @(posedge clk);
      #1;
      if (led !== l) n++;
    end
  endtask : blink

  task automatic conclude;
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  // Watchdog well beyond the few hundred cycles the sequence needs.
  initial begin
    #(40 * 20000);
    errors++;
    conclude();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    // Factory values after reset.
    rd(8'h0c, 32'h0202);
    rd(8'h14, 32'h005a);
    rd(8'h18, 32'h005a);
    rd(8'h24, 32'h00fe);
    rd(8'h2c, 32'h0);
    $display("test reset done");
    // Random tilts within range at factory scale.
    for (int i = 0; i < 4; i++) begin
      smp($random(seed) % 9000, $random(seed) % 9000);
    end
    $display("test default done");
    // Grads, milliradians, then a setting that overflows one word on X only.
    for (int m = 0; m < 3; m++) begin
      sc[0] = (m == 1) ? 1570 : 100;
      dp[0] = (m == 0) ? 2 : (m == 1) ? 0 : 3;
      wr(8'h14, 32'(sc[0]));
      wr(8'h0c, 32'((dp[0] << 8) | 2));
      smp(4500, 4500);
      smp(9000, -9000);
      smp(-9000, 9000);
    end
    $display("test units done");
    // Settings picked to fit one word for the offset checks.
    sc[0] = 90;
    dp[0] = 2;
    wr(8'h14, 32'd90);
    wr(8'h0c, 32'h0202);
    off[0] = 100;
    wr(8'h1c, 32'd100);
    // Still the clamped floor of the last sample taken under the old settings.
    rd(8'h00, 32'(-32768));
    smp(500, -300);
    sc[0] = 100;
    wr(8'h14, 32'd100);
    rd(8'h1c, 32'd100);
    smp(900, 900);
    $display("test offset done");
    // Zeroing X alone at the current tilt.
    wr(8'h28, 32'h1);
    smp(1800, 1800);
    off[0] = 1800 * 100 * 100 / 9000;
    rd(8'h1c, 32'(off[0]));
    rd(8'h20, 32'h0);
    smp(1800, 1800);
    $display("test zero done");
    // Read-only result, unmapped word.
    wr(8'h00, 32'h1234);
    rd(8'h00, 32'h0);
    MST.xfer(1'b0, 8'h30, 32'h0, q, r);
    chk(32'(r), 32'h2);
    $display("test access done");
    // Station address, pushbutton override, LED.
    wr(8'h24, 32'h12);
    rd(8'h24, 32'h12);
    chk(32'(station_addr), 32'h12);
    blink(64);
    chk(n, 8);
    button_n <= 1'b0;
    repeat (4) @(posedge clk);
    blink(32);
    chk(n, 0);
    chk({led, forced_rate, station_addr}, {2'b11, 8'hff});
    button_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk({forced_rate, station_addr}, {1'b0, 8'h12});
    $display("test station done");
    conclude();
  end
endmodule : tb
